// >>> verilog/lcfg_map.vh
// Constants for the link configuration-space command block.
// Assumes inclusion by bare name from the design file.
`ifndef LCFG_MAP_VH
`define LCFG_MAP_VH
`define LCFG_OFF_ID 8'h00
`define LCFG_OFF_CMD 8'h04
`define LCFG_CMD_RESET 16'h0000
`define LCFG_CMD_MASK 16'h0547
`define LCFG_BIT_IO 0
`define LCFG_BIT_MEM 1
`define LCFG_BIT_MASTER 2
`define LCFG_BIT_DERR 6
`define LCFG_BIT_FLOOD 8
`define LCFG_BIT_INTDIS 10
`define LCFG_UID_MAX 5'h1f
`define LCFG_HOST_UID 5'h00
`define LCFG_EXT_BUS_LSB 20
`define LCFG_EXT_DEV_LSB 15
`define LCFG_EXT_FUN_LSB 12
`define LCFG_EXT_REG_LSB 2
`endif

// >>> verilog/lcfg_cmd.v
// Configuration-space front end: device-number claim, header function 0, command register.
// Assumes all request inputs come from core logic on clock_i; warm and cold reset both reach nrst_i
// or warm_rst_i; the flood error and interrupt source inputs are synchronous.
module lcfg_cmd #(
  parameter [15:0] VENDOR_CODE = 16'h1234, // Arbitrary value
  parameter [15:0] DEVICE_CODE = 16'h5678, // Arbitrary value
  parameter [4:0] UNIT_COUNT = 5'h02,
  parameter [31:0] EXTRA_SPACES = 32'h0000_0000,
  parameter SUBTRACTIVE = 0,
  parameter BRIDGE = 0
) (
  // Clock and resets
  input wire clock_i,
  input wire nrst_i,
  input wire warm_rst_i,
  // Identifier assignment
  input wire [4:0] lowest_owned_identifier_i,
  // Configuration access
  input wire cfg_req_i,
  input wire cfg_write_i,
  input wire [4:0] cfg_dev_i,
  input wire [2:0] cfg_fun_i,
  input wire [7:0] cfg_off_i,
  input wire [3:0] cfg_be_i,
  input wire [31:0] cfg_wdata_i,
  output reg cfg_ack_o,
  output reg [31:0] cfg_rdata_o,
  // Flat extended address split
  input wire [27:0] sw_addr_i,
  output reg [7:0] ext_bus_o,
  output reg [4:0] ext_dev_o,
  output reg [2:0] ext_fun_o,
  output reg [9:0] ext_reg_o,
  // Inbound request decode
  input wire io_req_i,
  input wire mem_req_i,
  input wire compat_i,
  output reg io_accept_o,
  output reg mem_accept_o,
  // Own request issue
  input wire own_req_i,
  output reg own_req_grant_o,
  // Data errors
  input wire derr_seen_i,
  input wire fwd_done_err_i,
  output reg master_derr_o,
  output reg fwd_done_err_o,
  // Sync flood
  input wire flood_err_i,
  input wire link_init_i,
  output reg sync_gen_o,
  // Legacy interrupt
  input wire int_src_i,
  output reg legacy_interrupt_o,
  output reg int_msg_assert_o,
  output reg int_msg_deassert_o,
  // Command bits for other logic
  output reg [15:0] command_control_o
);
`include "lcfg_map.vh"

  // Timing overview:
  // every output but command_control_o is one register stage behind the inputs that feed it (that copy is two behind a write),
  // and every gate uses the stored command word, not the copy on command_control_o.
  // A configuration write lands at the edge that takes the request,
  // so a request one cycle later already sees the new enables.
  // The answer to a configuration access stands for exactly one cycle;
  // a missing answer is how the chain learns of a master abort.
  // Inputs are assumed to come from core logic on clock_i,
  // so none of them passes a synchroniser here.
  // Trade-off: one stage of latency everywhere buys flop-driven outputs.
  reg [15:0] command_control_reg;
  reg [15:0] command_control_next;
  reg int_sent_reg;
  reg int_sent_next;
  reg master_derr_next;
  wire hit;

  // Identifiers are five bits and a device may own a run of them
  // Device zero is never claimed, so only the host can be found there
  // Extra spaces are optional; a clear EXTRA_SPACES bit leaves that number silent
  // Device-number claim
  function claims;
    input [4:0] dev;
    input [4:0] base;
    reg [4:0] delta;
    begin
      delta = dev - base;
      if (dev == `LCFG_HOST_UID) begin
        claims = 1'b0; // Host keeps zero
      end else if (dev == base) begin
        claims = 1'b1;
      end else if (delta < UNIT_COUNT) begin
        claims = EXTRA_SPACES[delta];
      end else begin
        claims = 1'b0; // No claim
      end
    end
  endfunction

  // Byte-enable merge of a write into a stored 16-bit word
  function [15:0] byte_merge;
    input [15:0] old_word;
    input [15:0] new_word;
    input [1:0] lanes;
    reg [15:0] lane_mask;
    begin
      lane_mask = {{8{lanes[1]}}, {8{lanes[0]}}};
      byte_merge = (old_word & ~lane_mask) | (new_word & lane_mask);
    end
  endfunction

  // Space acceptance: enable bit, or compat traffic on a subtractive decoder
  function gate_accept;
    input req;
    input enable;
    input compat;
    begin
      gate_accept = req && (enable || (SUBTRACTIVE != 0 && compat));
    end
  endfunction

  // Readable view of the command word; hardwired positions forced to zero
  function [15:0] cmd_view;
    input [15:0] word;
    begin
      cmd_view = word & `LCFG_CMD_MASK;
    end
  endfunction

  // Only function 0 is implemented
  assign hit = cfg_req_i && cfg_fun_i == 3'h0 && claims(cfg_dev_i, lowest_owned_identifier_i);

  // Command write; only defined bits stored
  always @* begin
    command_control_next = command_control_reg;
    if (hit && cfg_write_i && cfg_off_i == `LCFG_OFF_CMD) begin
      command_control_next = byte_merge(command_control_reg, cfg_wdata_i[15:0], cfg_be_i[1:0])
        & `LCFG_CMD_MASK;
    end
  end

  // Interrupt message protocol:
  // one assertion message when the source rises while allowed,
  // one deassertion when the source drops or the disable bit is stored.
  // The sent flag never sets while disabled, so no stray assertion follows.
  // Outstanding interrupt message tracking
  always @* begin
    int_sent_next = int_sent_reg;
    if (int_sent_reg && (!int_src_i || command_control_reg[`LCFG_BIT_INTDIS])) begin
      int_sent_next = 1'b0;
    end else if (!int_sent_reg && int_src_i && !command_control_reg[`LCFG_BIT_INTDIS]) begin
      int_sent_next = 1'b1;
    end
  end

  // Master data error, sticky until cold reset
  always @* begin
    master_derr_next = master_derr_o;
    if (derr_seen_i && command_control_reg[`LCFG_BIT_DERR]) begin
      master_derr_next = 1'b1;
    end
  end

  // Reset policy:
  // warm and cold reset clear the command word and all gated outputs;
  // only the master data error flag survives a warm reset.
  // After a warm reset no message is outstanding, so the far side
  // must treat a pending interrupt as withdrawn.
  // Warm and cold both clear the command
  always @(posedge clock_i) begin
    if (!nrst_i || warm_rst_i) begin
      command_control_reg <= `LCFG_CMD_RESET;
    end else begin
      command_control_reg <= command_control_next;
    end
  end

  // Sent flag cleared by either reset
  always @(posedge clock_i) begin
    if (!nrst_i || warm_rst_i) begin
      int_sent_reg <= 1'b0;
    end else begin
      int_sent_reg <= int_sent_next;
    end
  end

  // Status-like flag cleared only by cold reset, held through warm reset
  always @(posedge clock_i) begin
    if (!nrst_i) begin
      master_derr_o <= 1'b0;
    end else begin
      master_derr_o <= master_derr_next;
    end
  end

  // Claim answer one cycle after request; silence means master abort
  always @(posedge clock_i) begin
    if (!nrst_i || warm_rst_i) begin
      cfg_ack_o <= 1'b0;
    end else begin
      cfg_ack_o <= hit;
    end
  end

  // Read data stands with the answer only, zero otherwise
  always @(posedge clock_i) begin
    if (!nrst_i || warm_rst_i) begin
      cfg_rdata_o <= 32'h0000_0000;
    end else begin
      cfg_rdata_o <= 32'h0000_0000;
      if (hit && !cfg_write_i) begin
        case (cfg_off_i)
          `LCFG_OFF_ID: cfg_rdata_o <= {DEVICE_CODE, VENDOR_CODE};
          `LCFG_OFF_CMD: cfg_rdata_o <= {16'h0000, cmd_view(command_control_reg)};
          default: cfg_rdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Software address fields; no range check, the host owns the map
  always @(posedge clock_i) begin
    if (!nrst_i || warm_rst_i) begin
      ext_bus_o <= 8'h00;
      ext_dev_o <= 5'h00;
      ext_fun_o <= 3'h0;
      ext_reg_o <= 10'h000;
    end else begin
      ext_bus_o <= sw_addr_i[27:`LCFG_EXT_BUS_LSB];
      ext_dev_o <= sw_addr_i[19:`LCFG_EXT_DEV_LSB];
      ext_fun_o <= sw_addr_i[14:`LCFG_EXT_FUN_LSB];
      ext_reg_o <= sw_addr_i[11:`LCFG_EXT_REG_LSB];
    end
  end

  // I/O space acceptance
  always @(posedge clock_i) begin
    if (!nrst_i || warm_rst_i) begin
      io_accept_o <= 1'b0;
    end else begin
      io_accept_o <= gate_accept(io_req_i, command_control_reg[`LCFG_BIT_IO], compat_i);
    end
  end

  // Memory space acceptance
  always @(posedge clock_i) begin
    if (!nrst_i || warm_rst_i) begin
      mem_accept_o <= 1'b0;
    end else begin
      mem_accept_o <= gate_accept(mem_req_i, command_control_reg[`LCFG_BIT_MEM], compat_i);
    end
  end

  // Own requests only; forwarding of others is never gated here
  always @(posedge clock_i) begin
    if (!nrst_i || warm_rst_i) begin
      own_req_grant_o <= 1'b0;
    end else begin
      own_req_grant_o <= own_req_i && command_control_reg[`LCFG_BIT_MASTER];
    end
  end

  // Bridges only mark forwarded done responses; tunnels leave it low
  always @(posedge clock_i) begin
    if (!nrst_i || warm_rst_i) begin
      fwd_done_err_o <= 1'b0;
    end else begin
      fwd_done_err_o <= BRIDGE != 0 && fwd_done_err_i && command_control_reg[`LCFG_BIT_DERR];
    end
  end

  // Flood only when enabled; init sync always allowed, pass-through not gated
  always @(posedge clock_i) begin
    if (!nrst_i || warm_rst_i) begin
      sync_gen_o <= 1'b0;
    end else begin
      sync_gen_o <= link_init_i || (flood_err_i && command_control_reg[`LCFG_BIT_FLOOD]);
    end
  end

  // Own pin only; message forwarding lies outside this block
  always @(posedge clock_i) begin
    if (!nrst_i || warm_rst_i) begin
      legacy_interrupt_o <= 1'b0;
    end else begin
      legacy_interrupt_o <= int_src_i && !command_control_reg[`LCFG_BIT_INTDIS];
    end
  end

  // Assertion message on the rise of the sent flag
  always @(posedge clock_i) begin
    if (!nrst_i || warm_rst_i) begin
      int_msg_assert_o <= 1'b0;
    end else begin
      int_msg_assert_o <= !int_sent_reg && int_sent_next;
    end
  end

  // Deassertion message on the fall, including a disable while sent
  always @(posedge clock_i) begin
    if (!nrst_i || warm_rst_i) begin
      int_msg_deassert_o <= 1'b0;
    end else begin
      int_msg_deassert_o <= int_sent_reg && !int_sent_next;
    end
  end

  // Command copy for other logic, one cycle behind the store
  always @(posedge clock_i) begin
    if (!nrst_i || warm_rst_i) begin
      command_control_o <= `LCFG_CMD_RESET;
    end else begin
      command_control_o <= command_control_reg;
    end
  end
endmodule

// >>> dv/lcfg_chk_asserts.sv
// Port-timing checker for lcfg_cmd.
// Assumes default parameters and compat_i held low.
module lcfg_chk (
  input wire clock_i, nrst_i, warm_rst_i, cfg_req_i, cfg_write_i, cfg_ack_o,
  input wire io_req_i, mem_req_i, own_req_i, flood_err_i, link_init_i, int_src_i,
  input wire io_accept_o, mem_accept_o, own_req_grant_o, sync_gen_o, legacy_interrupt_o, int_msg_deassert_o,
  input wire [4:0] lowest_owned_identifier_i, cfg_dev_i,
  input wire [2:0] cfg_fun_i,
  input wire [7:0] cfg_off_i,
  input wire [3:0] cfg_be_i,
  input wire [31:0] cfg_wdata_i, cfg_rdata_o,
  input wire [15:0] command_control_o
);
  // Outputs lag the stored command by one edge, so command_control_o is the gate in force
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i || warm_rst_i);
  wire [15:0] cmd = command_control_o;
  a_io_gate: assert property (io_accept_o == ($past(io_req_i) && cmd[0])) else $error("io accept wrong");
  a_mem_gate: assert property (mem_accept_o == ($past(mem_req_i) && cmd[1])) else $error("mem accept wrong");
  a_master_gate: assert property (own_req_grant_o == ($past(own_req_i) && cmd[2])) else $error("grant wrong");
  a_sync_gen: assert property (sync_gen_o == ($past(link_init_i) || ($past(flood_err_i) && cmd[8])))
    else $error("sync wrong");
  a_int_gate: assert property (legacy_interrupt_o == ($past(int_src_i) && !cmd[10])) else $error("int wrong");
  a_cmd_mask: assert property ((cmd & 16'hfab8) == 16'h0000) else $error("hardwired bit set");
  a_ack_claim: assert property (cfg_ack_o == $past(cfg_req_i && cfg_fun_i == 3'h0
    && cfg_dev_i == lowest_owned_identifier_i)) else $error("claim wrong");
  a_read_value: assert property (cfg_ack_o && $past(!cfg_write_i && cfg_off_i == 8'h04)
    |-> cfg_rdata_o == {16'h0000, cmd}) else $error("read value wrong");
  a_write_land: assert property (cfg_req_i && cfg_write_i && cfg_off_i == 8'h04 && cfg_be_i[0]
    && cfg_fun_i == 3'h0 && cfg_dev_i == lowest_owned_identifier_i ##1 !cfg_req_i
    |-> ##1 cmd[7:0] == ($past(cfg_wdata_i[7:0], 2) & 8'h47)) else $error("write lost");
  a_warm_clear: assert property (@(posedge clock_i) disable iff (!nrst_i) warm_rst_i |=> cmd == 16'h0000)
    else $error("warm reset kept command");
  // Main scenarios
  c_read: cover property (cfg_ack_o && cmd[10]);
  c_deassert: cover property (int_msg_deassert_o);
  c_flood: cover property (sync_gen_o && cmd[8]);
endmodule
bind lcfg_cmd lcfg_chk u_chk (.clock_i, .nrst_i, .warm_rst_i, .cfg_req_i, .cfg_write_i, .cfg_ack_o, .io_req_i,
  .mem_req_i, .own_req_i, .flood_err_i, .link_init_i, .int_src_i, .io_accept_o, .mem_accept_o, .own_req_grant_o,
  .sync_gen_o, .legacy_interrupt_o, .int_msg_deassert_o, .lowest_owned_identifier_i, .cfg_dev_i, .cfg_fun_i,
  .cfg_off_i, .cfg_be_i, .cfg_wdata_i, .cfg_rdata_o, .command_control_o);

// >>> dv/lcfg_host.sv
// Host bridge model issuing configuration accesses.
// Assumes the answer comes one cycle after the request pulse.
module lcfg_host (
  input wire clock_i,
  input wire cfg_ack_i,
  input wire [31:0] cfg_rdata_i,
  output logic cfg_req_o, cfg_write_o,
  output logic [4:0] cfg_dev_o,
  output logic [2:0] cfg_fun_o,
  output logic [7:0] cfg_off_o,
  output logic [3:0] cfg_be_o,
  output logic [31:0] cfg_wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {cfg_req_o, cfg_write_o, cfg_dev_o, cfg_fun_o, cfg_off_o, cfg_be_o, cfg_wdata_o} = '0;
  // One access; answer taken in the cycle it stands
  task automatic xfer(input logic w, input logic [7:0] df, input logic [7:0] o, input logic [31:0] wd,
    output logic ack, output logic [31:0] rd);
    @(negedge clock_i);
    {cfg_req_o, cfg_write_o, cfg_dev_o, cfg_fun_o, cfg_off_o, cfg_be_o, cfg_wdata_o} = {2'b11 & {1'b1, w}, df, o, 4'hf, wd};
    @(negedge clock_i);
    cfg_req_o = 1'b0;
    cfg_wdata_o = ~wd; // Released lines must not keep the old value
    ack = cfg_ack_i;
    rd = cfg_rdata_i;
  endtask
endmodule

// >>> dv/testbench.sv
// Self-checking bench for lcfg_cmd.
// Assumes lcfg_host drives configuration and the checker is bound.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ME = 8'h18; // Device 3, function 0
  logic clock_i = 1'b0, nrst_i = 1'b0, warm_rst_i = 1'b0, ack, ok;
  logic [6:0] stim = 7'h00;
  logic [31:0] rd;
  logic [15:0] gv [6] = '{16'h0000, 16'h0001, 16'h0002, 16'h0004, 16'h0100, 16'h0400};
  logic [7:0] bad [3] = '{8'h20, 8'h00, 8'h19};
  int err_total = 0, total_checks = 0;
  wire req, wr, cack, ioa, mema, gnt, mderr, sync, lint, deas, asrt, fde;
  wire [4:0] dev, edev;
  wire [2:0] fun, efun;
  wire [7:0] off, ebus;
  wire [3:0] be;
  wire [9:0] ereg;
  wire [31:0] wdata, rdata;
  wire [15:0] cmd;
  lcfg_host host (.clock_i, .cfg_ack_i(cack), .cfg_rdata_i(rdata), .cfg_req_o(req), .cfg_write_o(wr),
    .cfg_dev_o(dev), .cfg_fun_o(fun), .cfg_off_o(off), .cfg_be_o(be), .cfg_wdata_o(wdata));
  lcfg_cmd DUT (.clock_i, .nrst_i, .warm_rst_i, .lowest_owned_identifier_i(5'h03), .cfg_req_i(req),
    .cfg_write_i(wr), .cfg_dev_i(dev), .cfg_fun_i(fun), .cfg_off_i(off), .cfg_be_i(be), .cfg_wdata_i(wdata),
    .cfg_ack_o(cack), .cfg_rdata_o(rdata), .sw_addr_i({8'ha5, 5'h13, 3'h6, 10'h2ab, 2'b00}), .ext_bus_o(ebus),
    .ext_dev_o(edev), .ext_fun_o(efun), .ext_reg_o(ereg), .io_req_i(stim[6]), .mem_req_i(stim[5]),
    .compat_i(1'b0), .io_accept_o(ioa), .mem_accept_o(mema), .own_req_i(stim[4]), .own_req_grant_o(gnt),
    .derr_seen_i(stim[3]), .fwd_done_err_i(stim[3]), .master_derr_o(mderr), .fwd_done_err_o(fde),
    .flood_err_i(stim[2]), .link_init_i(stim[1]), .sync_gen_o(sync), .int_src_i(stim[0]),
    .legacy_interrupt_o(lint), .int_msg_assert_o(asrt), .int_msg_deassert_o(deas), .command_control_o(cmd));
  // Free-running 100 MHz clock
  initial forever #5 clock_i = ~clock_i;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Hang guard, far beyond the roughly 53 cycles the tests need
  initial begin
    #20us;
    err_total++;
    final_report();
  end
  // Test sequence
  initial begin
    repeat (2) @(negedge clock_i);
    nrst_i = 1'b1;
    host.xfer(1'b0, ME, 8'h04, 32'h0, ack, rd);
    chk("cmd reset", 32'h0, rd);
    host.xfer(1'b1, ME, 8'h04, 32'hffff_ffff, ack, rd);
    host.xfer(1'b0, ME, 8'h04, 32'h0, ack, rd);
    chk("cmd mask", 32'h0000_0547, rd);
    host.xfer(1'b0, ME, 8'h00, 32'h0, ack, rd);
    chk("header claim", 32'h1, {31'h0, ack});
    chk("split", {6'h0, 8'ha5, 5'h13, 3'h6, 10'h2ab}, {6'h0, ebus, edev, efun, ereg});
    foreach (bad[i]) begin
      host.xfer(1'b0, bad[i], 8'h04, 32'h0, ack, rd);
      chk("no claim", 32'h0, {31'h0, ack});
    end
    $display("test claim done");
    // Every enable bit alone but the data error bit; data errors seen without the response bit stay unflagged
    foreach (gv[i]) begin
      host.xfer(1'b1, ME, 8'h04, {16'h0, gv[i]}, ack, rd);
      stim = 7'b1111101;
      repeat (2) @(negedge clock_i);
      chk("gates", {gv[i][0], gv[i][1], gv[i][2], gv[i][8], ~gv[i][10], 2'b00},
        {ioa, mema, gnt, sync, lint, mderr, fde});
      stim = 7'h00;
    end
    host.xfer(1'b1, ME, 8'h04, 32'h0040, ack, rd);
    stim = 7'h09;
    ok = 1'b0;
    repeat (2) begin
      @(negedge clock_i);
      if (asrt === 1'b1) ok = 1'b1;
    end
    chk("assert msg", 32'h1, {31'h0, ok});
    chk("data error flag", 32'h1, {31'h0, mderr});
    host.xfer(1'b1, ME, 8'h04, 32'h0400, ack, rd);
    ok = 1'b0;
    repeat (4) begin
      if (deas === 1'b1) ok = 1'b1;
      @(negedge clock_i);
    end
    chk("deassert msg", 32'h1, {31'h0, ok});
    $display("test gates done");
    stim = 7'h00;
    warm_rst_i = 1'b1;
    @(negedge clock_i);
    warm_rst_i = 1'b0;
    host.xfer(1'b0, ME, 8'h04, 32'h0, ack, rd);
    chk("warm cmd", 32'h0, rd);
    chk("warm keeps flag", 32'h1, {31'h0, mderr});
    $display("test reset done");
    final_report();
  end
endmodule
